//--- hdl/drive_stop_ramp_sequencer.sv
// Stop, ramp and restart sequencer for an inverter output bridge.
`timescale 1ns/1ps
`default_nettype none
module drive_stop_ramp_sequencer #(
	parameter int unsigned REVERSE_CYC = stop_ramp_pkg::REVERSE_DELAY_CYC,
	parameter int unsigned COAST_CYC = stop_ramp_pkg::COAST_INHIBIT_CYC,
	parameter int unsigned HOLD_CYC = stop_ramp_pkg::RAMP_HOLD_CYC,
	parameter int unsigned LOCK_CYC = stop_ramp_pkg::LOCK_HOLD_CYC,
	parameter int unsigned MIN_INJ_CYC = stop_ramp_pkg::MIN_INJECT_CYC,
	parameter int unsigned SEC_CYC = stop_ramp_pkg::CLK_HZ
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Terminals and measurements
	input wire stop_ramp_pkg::term_in_t term_in,
	input wire logic [15:0] freq_ref,
	input wire logic [15:0] bus_voltage,
	input wire logic regen_seen,
	input wire logic trip,
	// Bridge demand
	output stop_ramp_pkg::drive_out_t drive_out,
	output logic inhibit_active
);
	import stop_ramp_pkg::*;

	// ----------------------------------------------------------------
	// Terminal synchronisers
	// ----------------------------------------------------------------
	logic [4:0] sync1_q, sync2_q, sync3_q, term_q;
	logic [4:0] term_d;
	term_in_t term;
	// A pin change counts only once the second and third stages agree, so a one-cycle glitch is dropped.
	always_comb begin
		term_d = term_q;
		for (int i = 0; i < 5; i++) begin
			if (sync2_q[i] == sync3_q[i]) begin
				term_d[i] = sync3_q[i];
			end
		end
	end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_q <= 5'h00;
			sync2_q <= 5'h00;
			sync3_q <= 5'h00;
			term_q <= 5'h00;
		end else begin
			sync1_q <= term_in;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			term_q <= term_d;
		end
	end
	assign term = term_in_t'(term_q);
	logic run_fwd_cmd, run_rev_cmd, run_cmd;
	assign run_fwd_cmd = term.run_fwd | (term.run & term.not_stop);
	assign run_rev_cmd = term.run_rev;
	assign run_cmd = term.enable & (run_fwd_cmd ^ run_rev_cmd);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [1:0] ramp_style_q, ramp_style_d;
	logic [2:0] stop_style_q, stop_style_d;
	logic [31:0] decel_step_q, decel_step_d;
	logic [15:0] inj_level_q, inj_level_d, inj_time_q, inj_time_d;
	logic [15:0] bus_upper_q, bus_upper_d, bus_lower_q, bus_lower_d, rated_v_q, rated_v_d;
	logic [15:0] motor_i_q, motor_i_d, drive_i_q, drive_i_d, rdata_d, ilim_q, ilim_d;
	seq_state_t state_q, state_d;
	logic [15:0] freq_q, freq_d;
	always_comb begin
		ramp_style_d = ramp_style_q;
		stop_style_d = stop_style_q;
		decel_step_d = decel_step_q;
		inj_level_d = inj_level_q;
		inj_time_d = inj_time_q;
		bus_upper_d = bus_upper_q;
		bus_lower_d = bus_lower_q;
		rated_v_d = rated_v_q;
		motor_i_d = motor_i_q;
		drive_i_d = drive_i_q;
		if (reg_wr) begin
			case (reg_addr)
				REG_RAMP_STYLE: begin
					// Style 3 is undefined and ignored.
					if (reg_wdata[1:0] != 2'h3) begin
						ramp_style_d = reg_wdata[1:0];
					end
				end
				REG_STOP_STYLE: begin
					if (reg_wdata[2:0] <= 3'h4) begin
						stop_style_d = reg_wdata[2:0];
					end
				end
				REG_DECEL_STEP: decel_step_d = (reg_wdata == 16'h0000) ? 32'h00000001 : {16'h0000, reg_wdata};
				REG_INJ_LEVEL: inj_level_d = reg_wdata;
				REG_INJ_TIME: inj_time_d = reg_wdata;
				REG_BUS_UPPER: bus_upper_d = reg_wdata;
				REG_BUS_LOWER: bus_lower_d = reg_wdata;
				REG_RATED_V: rated_v_d = reg_wdata;
				REG_MOTOR_I: motor_i_d = (reg_wdata == 16'h0000) ? 16'h0001 : reg_wdata;
				REG_DRIVE_I: drive_i_d = reg_wdata;
				default: begin
				end
			endcase
		end
		rdata_d = 16'h0000;
		if (reg_rd) begin
			case (reg_addr)
				REG_RAMP_STYLE: rdata_d = {14'h0000, ramp_style_q};
				REG_STOP_STYLE: rdata_d = {13'h0000, stop_style_q};
				REG_DECEL_STEP: begin
					// The reset rate needs more than 16 bits, so a read of it saturates.
					rdata_d = (decel_step_q > 32'h0000ffff) ? 16'hffff : decel_step_q[15:0];
				end
				REG_INJ_LEVEL: rdata_d = inj_level_q;
				REG_INJ_TIME: rdata_d = inj_time_q;
				REG_BUS_UPPER: rdata_d = bus_upper_q;
				REG_BUS_LOWER: rdata_d = bus_lower_q;
				REG_RATED_V: rdata_d = rated_v_q;
				REG_MOTOR_I: rdata_d = motor_i_q;
				REG_DRIVE_I: rdata_d = drive_i_q;
				REG_STATUS: rdata_d = {12'h000, state_q};
				REG_FREQ: rdata_d = freq_q;
				REG_ILIM: rdata_d = ilim_q;
				default: rdata_d = 16'h0000;
			endcase
		end
	end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ramp_style_q <= RAMP_STYLE_RST;
			stop_style_q <= STOP_STYLE_RST;
			decel_step_q <= 32'(DECEL_STEP_CYC);
			inj_level_q <= INJ_LEVEL_RST;
			inj_time_q <= INJ_TIME_RST;
			bus_upper_q <= BUS_UPPER_RST;
			bus_lower_q <= BUS_LOWER_RST;
			rated_v_q <= RATED_V_RST;
			motor_i_q <= MOTOR_I_RST;
			drive_i_q <= DRIVE_I_RST;
			reg_rdata <= 16'h0000;
		end else begin
			ramp_style_q <= ramp_style_d;
			stop_style_q <= stop_style_d;
			decel_step_q <= decel_step_d;
			inj_level_q <= inj_level_d;
			inj_time_q <= inj_time_d;
			bus_upper_q <= bus_upper_d;
			bus_lower_q <= bus_lower_d;
			rated_v_q <= rated_v_d;
			motor_i_q <= motor_i_d;
			drive_i_q <= drive_i_d;
			reg_rdata <= rdata_d;
		end
	end

	// ----------------------------------------------------------------
	// Current limit
	// ----------------------------------------------------------------
	// The full motor-map equation is not evaluated; the limit scales
	// inversely with motor current, which keeps the divide simple.
	logic [31:0] ilim_raw;
	assign ilim_raw = (32'(ILIM_DEFAULT_PCT) * 32'(drive_i_q)) / 32'(motor_i_q);
	always_comb begin
		ilim_d = (ilim_raw > 32'(ILIM_MAX_PCT)) ? ILIM_MAX_PCT : ilim_raw[15:0];
	end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ilim_q <= ILIM_DEFAULT_PCT;
		end else begin
			ilim_q <= ilim_d;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	logic [31:0] timer_q, timer_d, step_q, step_d, inj_cyc;
	logic [47:0] inj_prod;
	logic hold_q, hold_d, dir_q, dir_d;
	drive_out_t out_d;
	logic want_rev, ramp_tick;
	assign want_rev = run_rev_cmd;
	assign ramp_tick = (step_q + 32'h1 >= decel_step_q) && !hold_q;
	always_comb begin
		// The product saturates so that a long injection time can never wrap to a short one.
		inj_prod = 48'(inj_time_q) * 48'(SEC_CYC);
		inj_cyc = (inj_prod > 48'h0000ffffffff) ? 32'hffffffff : inj_prod[31:0];
		if (stop_style_q == STOP_DC_TIMED && inj_cyc < MIN_INJ_CYC) begin
			inj_cyc = MIN_INJ_CYC;
		end
	end
	always_comb begin
		state_d = state_q;
		timer_d = timer_q + 32'h1;
		step_d = 32'h0;
		freq_d = freq_q;
		dir_d = dir_q;
		// Hysteresis holds the ramp between the two bus levels.
		hold_d = 1'b0;
		if (ramp_style_q != RAMP_FAST) begin
			hold_d = hold_q ? (bus_voltage >= bus_lower_q) : (bus_voltage > bus_upper_q);
		end
		case (state_q)
			ST_READY: begin
				freq_d = 16'h0000;
				// Starts are taken here only, so no stop sequence can be cut short by a new run.
				if (run_cmd && !trip) begin
					dir_d = want_rev;
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				freq_d = freq_ref;
				if (!run_cmd) begin
					state_d = ST_DECEL;
				end else if (want_rev != dir_q) begin
					state_d = ST_REVERSE;
				end
			end
			ST_REVERSE: begin
				// The bridge stays enabled through the reversal wait and no stop sequence runs.
				if (!run_cmd) begin
					state_d = ST_DECEL;
				end else if (want_rev == dir_q) begin
					state_d = ST_RUN;
				end else if (timer_q + 32'h1 >= REVERSE_CYC) begin
					dir_d = want_rev;
					state_d = ST_RUN;
				end
			end
			ST_DECEL: begin
				// A zero step count is never stored, so the ramp always moves unless held.
				step_d = step_q + 32'h1;
				if (ramp_tick) begin
					step_d = 32'h0;
					freq_d = (freq_q == 16'h0000) ? 16'h0000 : freq_q - 16'h0001;
				end else if (hold_q) begin
					step_d = step_q;
				end
				if (freq_q == 16'h0000) begin
					state_d = (stop_style_q == STOP_RAMP_DC) ? ST_DC_INJ : ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (timer_q + 32'h1 >= HOLD_CYC) begin
					state_d = ST_READY;
				end
			end
			ST_INJ_5HZ: begin
				freq_d = INJECT_5HZ;
				if (!regen_seen) begin
					freq_d = 16'h0000;
					state_d = ST_DC_INJ;
				end
			end
			ST_DC_INJ: begin
				freq_d = 16'h0000;
				if (timer_q + 32'h1 >= inj_cyc) begin
					state_d = (stop_style_q == STOP_DC_TIMED) ? ST_DC_LOCK : ST_READY;
				end
			end
			ST_DC_LOCK: begin
				if (timer_q + 32'h1 >= LOCK_CYC) begin
					state_d = ST_READY;
				end
			end
			ST_INHIBIT: begin
				freq_d = 16'h0000;
				if (timer_q + 32'h1 >= COAST_CYC) begin
					state_d = ST_READY;
				end
			end
			default: state_d = ST_READY;
		endcase
		// Stop entry from running chooses the style's first phase.
		if (state_d == ST_DECEL && state_q != ST_DECEL) begin
			case (stop_style_q)
				STOP_COAST: begin
					state_d = ST_INHIBIT;
					freq_d = 16'h0000;
				end
				STOP_INJ_ZS: begin
					// The running demand must not leak into the first injection cycle.
					state_d = ST_INJ_5HZ;
					freq_d = INJECT_5HZ;
				end
				STOP_DC_TIMED: begin
					state_d = ST_DC_INJ;
					freq_d = 16'h0000;
				end
				default: state_d = ST_DECEL;
			endcase
		end
		// A trip is handled like opening enable: coast, then inhibit.
		if ((!term.enable || trip) && state_q != ST_READY && state_q != ST_INHIBIT) begin
			state_d = ST_INHIBIT;
			freq_d = 16'h0000;
		end
		if (state_d != state_q) begin
			timer_d = 32'h0;
			step_d = 32'h0;
		end
	end
	// Outputs follow the next state so that they change together with the state register.
	always_comb begin
		out_d.dir_rev = dir_d;
		out_d.freq = freq_d;
		out_d.bridge_en = (state_d != ST_READY) && (state_d != ST_INHIBIT);
		out_d.inj_dc = (state_d == ST_DC_INJ) || (state_d == ST_DC_LOCK);
		out_d.inj_5hz = (state_d == ST_INJ_5HZ);
		out_d.inj_level = (out_d.inj_dc || out_d.inj_5hz) ? inj_level_q : 16'h0000;
		out_d.volt_limit = (ramp_style_q == RAMP_STD_HIV) ?
			16'((32'(rated_v_q) * VBOOST_NUM) / VBOOST_DEN) : rated_v_q;
	end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= ST_READY;
			timer_q <= 32'h0;
			step_q <= 32'h0;
			freq_q <= 16'h0000;
			hold_q <= 1'b0;
			dir_q <= 1'b0;
			drive_out <= '0;
			inhibit_active <= 1'b0;
		end else begin
			state_q <= state_d;
			timer_q <= timer_d;
			step_q <= step_d;
			freq_q <= freq_d;
			hold_q <= hold_d;
			dir_q <= dir_d;
			drive_out <= out_d;
			inhibit_active <= (state_d == ST_INHIBIT);
		end
	end
endmodule
`default_nettype wire

//--- hdl/stop_ramp_pkg.sv
// Package with constants and types for the drive stop and ramp sequencer.
package stop_ramp_pkg;
	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned REVERSE_DELAY_MS = 65;
	localparam int unsigned COAST_INHIBIT_MS = 2000;
	localparam int unsigned RAMP_HOLD_MS = 1000;
	localparam int unsigned LOCK_HOLD_MS = 1000;
	localparam int unsigned MIN_INJECT_MS = 1000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	localparam int unsigned REVERSE_DELAY_CYC = REVERSE_DELAY_MS * CYC_PER_MS;
	localparam int unsigned COAST_INHIBIT_CYC = COAST_INHIBIT_MS * CYC_PER_MS;
	localparam int unsigned RAMP_HOLD_CYC = RAMP_HOLD_MS * CYC_PER_MS;
	localparam int unsigned LOCK_HOLD_CYC = LOCK_HOLD_MS * CYC_PER_MS;
	localparam int unsigned MIN_INJECT_CYC = MIN_INJECT_MS * CYC_PER_MS;
	// Frequency in 0.01 Hz units; default fall 100 Hz per 10 s.
	localparam int unsigned DECEL_HZ_DEFAULT = 100;
	localparam int unsigned DECEL_S_DEFAULT = 10;
	localparam int unsigned DECEL_STEP_CYC = (DECEL_S_DEFAULT * CLK_HZ) / (DECEL_HZ_DEFAULT * 100);
	localparam logic [15:0] INJECT_5HZ = 16'h01f4;
	// Voltage scale: rated voltage times 1.2 as 6/5.
	localparam int unsigned VBOOST_NUM = 6;
	localparam int unsigned VBOOST_DEN = 5;
	// Current limit in percent of rated active current.
	localparam logic [15:0] ILIM_DEFAULT_PCT = 16'h00a5;
	localparam logic [15:0] ILIM_MAX_PCT = 16'h03e8;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_RAMP_STYLE = 4'h0;
	localparam logic [3:0] REG_STOP_STYLE = 4'h1;
	localparam logic [3:0] REG_DECEL_STEP = 4'h2;
	localparam logic [3:0] REG_INJ_LEVEL = 4'h3;
	localparam logic [3:0] REG_INJ_TIME = 4'h4;
	localparam logic [3:0] REG_BUS_UPPER = 4'h5;
	localparam logic [3:0] REG_BUS_LOWER = 4'h6;
	localparam logic [3:0] REG_RATED_V = 4'h7;
	localparam logic [3:0] REG_MOTOR_I = 4'h8;
	localparam logic [3:0] REG_DRIVE_I = 4'h9;
	localparam logic [3:0] REG_STATUS = 4'ha;
	localparam logic [3:0] REG_FREQ = 4'hb;
	localparam logic [3:0] REG_ILIM = 4'hc;
	localparam logic [1:0] RAMP_STYLE_RST = 2'h1;
	localparam logic [2:0] STOP_STYLE_RST = 3'h1;
	localparam logic [15:0] INJ_LEVEL_RST = 16'h0032;
	localparam logic [15:0] INJ_TIME_RST = 16'h0001;
	localparam logic [15:0] BUS_UPPER_RST = 16'h02ee;
	localparam logic [15:0] BUS_LOWER_RST = 16'h02d0;
	localparam logic [15:0] RATED_V_RST = 16'h0190;
	localparam logic [15:0] MOTOR_I_RST = 16'h0064;
	localparam logic [15:0] DRIVE_I_RST = 16'h0064;
	// ----------------------------------------------------------------
	// Encodings and carriers
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		RAMP_FAST = 2'h0,
		RAMP_STD = 2'h1,
		RAMP_STD_HIV = 2'h2
	} ramp_style_t;
	typedef enum logic [2:0] {
		STOP_COAST = 3'h0,
		STOP_RAMP = 3'h1,
		STOP_RAMP_DC = 3'h2,
		STOP_INJ_ZS = 3'h3,
		STOP_DC_TIMED = 3'h4
	} stop_style_t;
	typedef enum logic [3:0] {
		ST_READY = 4'h0,
		ST_RUN = 4'h1,
		ST_REVERSE = 4'h2,
		ST_DECEL = 4'h3,
		ST_HOLD = 4'h4,
		ST_DC_INJ = 4'h5,
		ST_INJ_5HZ = 4'h6,
		ST_DC_LOCK = 4'h7,
		ST_INHIBIT = 4'h8
	} seq_state_t;
	typedef struct packed {
		logic enable;
		logic run_fwd;
		logic run_rev;
		logic run;
		logic not_stop;
	} term_in_t;
	typedef struct packed {
		logic bridge_en;
		logic dir_rev;
		logic [15:0] freq;
		logic [15:0] inj_level;
		logic inj_dc;
		logic inj_5hz;
		logic [15:0] volt_limit;
	} drive_out_t;
endpackage

//--- bench/stop_ramp_monitor.sv
// Port-level checks on the stop and ramp sequencer.
`timescale 1ns/1ps
`default_nettype none
module stop_ramp_monitor (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Register port
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	// Terminals and bridge
	input wire stop_ramp_pkg::term_in_t term_in,
	input wire stop_ramp_pkg::drive_out_t drive_out,
	input wire logic inhibit_active
);
	import stop_ramp_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	sequence s_enable_open;
		$fell(term_in.enable) ##0 drive_out.bridge_en;
	endsequence
	sequence s_coasting;
		!drive_out.bridge_en && inhibit_active;
	endsequence
	a_enable_coast: assert property (s_enable_open |-> ##[1:8] s_coasting)
		else $error("enable opened without a coast stop");
	a_coast_off: assert property (inhibit_active |-> !drive_out.bridge_en)
		else $error("bridge enabled during coast inhibit");
	a_inhibit_span: assert property ($rose(inhibit_active) |=> inhibit_active [*8])
		else $error("coast inhibit ended early");
	a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data outside its cycle");
	a_low_freq_inj: assert property (drive_out.inj_5hz |-> drive_out.freq == INJECT_5HZ)
		else $error("low frequency injection not at 5 Hz");
	a_inj_single: assert property (!(drive_out.inj_dc && drive_out.inj_5hz))
		else $error("both injection kinds at once");
	a_inj_bridge: assert property ((drive_out.inj_dc || drive_out.inj_5hz) |-> drive_out.bridge_en)
		else $error("injection with bridge off");
	a_stop_at_zero: assert property ($fell(drive_out.bridge_en) && !inhibit_active |->
		$past(drive_out.freq) == 16'h0000) else $error("bridge dropped above zero frequency");
endmodule
bind drive_stop_ramp_sequencer stop_ramp_monitor mon (.ref_clk(ref_clk), .arst_n(arst_n), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .term_in(term_in), .drive_out(drive_out), .inhibit_active(inhibit_active));
`default_nettype wire

//--- bench/motor_bridge_model.sv
// Behavioural output bridge and induction motor seen from the sequencer.
`timescale 1ns/1ps
`default_nettype none
module motor_bridge_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Bridge demand and scenario knobs
	input wire stop_ramp_pkg::drive_out_t drive_out,
	input wire logic [1:0] bus_mode,
	input wire logic regen_stuck,
	// Measurements
	output logic [15:0] bus_voltage,
	output logic regen_seen
);
	import stop_ramp_pkg::*;
	logic [7:0] slow_q;
	logic [7:0] slow_d;
	// Regen fades after a short 5 Hz spell; regen_stuck keeps it flowing.
	always_comb begin
		slow_d = drive_out.inj_5hz ? ((slow_q == 8'hff) ? slow_q : slow_q + 8'h01) : 8'h00;
	end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			slow_q <= 8'h00;
		end else begin
			slow_q <= slow_d;
		end
	end
	assign regen_seen = drive_out.inj_5hz && (regen_stuck || slow_q < 8'h0c);
	always_comb begin
		case (bus_mode)
			2'h1: bus_voltage = 16'h02e0;
			2'h2: bus_voltage = 16'h0300;
			default: bus_voltage = 16'h02a0;
		endcase
	end
endmodule
`default_nettype wire

//--- bench/drive_stop_ramp_sequencer_tb.sv
// Self-checking bench for the stop and ramp sequencer.
`timescale 1ns/1ps
`default_nettype none
module drive_stop_ramp_sequencer_tb;
	import stop_ramp_pkg::*;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	term_in_t term = '0;
	logic [15:0] freq_ref = 16'h0010;
	logic [15:0] bus_voltage;
	logic regen_seen;
	logic trip = 1'b0;
	drive_out_t drv;
	logic inhibit_active;
	logic [1:0] bus_mode = 2'h0;
	logic regen_stuck = 1'b0;
	int err_count = 0;
	int n_compared = 0;
	always #2.5 ref_clk = ~ref_clk;
	// Short phase timers keep each stop sequence to tens of cycles.
	drive_stop_ramp_sequencer #(.REVERSE_CYC(20), .COAST_CYC(40), .HOLD_CYC(30), .LOCK_CYC(30), .MIN_INJ_CYC(10),
		.SEC_CYC(10)) dut (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .term_in(term), .freq_ref(freq_ref),
		.bus_voltage(bus_voltage), .regen_seen(regen_seen), .trip(trip), .drive_out(drv),
		.inhibit_active(inhibit_active));
	motor_bridge_model far (.ref_clk(ref_clk), .arst_n(arst_n), .drive_out(drv), .bus_mode(bus_mode),
		.regen_stuck(regen_stuck), .bus_voltage(bus_voltage), .regen_seen(regen_seen));
	task close_out;
		$display("Compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task chk_in(input int got, input int lo, input int hi);
		n_compared++;
		if (got < lo || got > hi) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, lo);
		end
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task rd_chk(input logic [3:0] a, input logic [15:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask
	function automatic logic pick(input int s);
		case (s)
			0: return drv.bridge_en;
			1: return inhibit_active;
			2: return drv.inj_dc;
			3: return drv.inj_5hz;
			4: return drv.dir_rev;
			default: return drv.freq === 16'h0000;
		endcase
	endfunction
	task automatic wait_sig(input int s, input logic lvl, output int cyc);
		cyc = 0;
		while (pick(s) !== lvl && cyc < 400) begin
			@(posedge ref_clk);
			#1;
			cyc++;
		end
	endtask
	task term_set(input logic en, input logic fwd, input logic rev);
		@(posedge ref_clk);
		term <= '{enable: en, run_fwd: fwd, run_rev: rev, run: 1'b0, not_stop: 1'b0};
	endtask
	task go(input logic rev);
		int c;
		term_set(1'b1, !rev, rev);
		wait_sig(0, 1'b1, c);
		chk_in(c, 1, 8);
		repeat (30) @(posedge ref_clk);
		#1;
	endtask
	task t_regs;
		rd_chk(REG_STOP_STYLE, 16'h0001);
		wr(REG_STOP_STYLE, 16'h0005);
		rd_chk(REG_STOP_STYLE, 16'h0001);
		wr(REG_RAMP_STYLE, 16'h0003);
		rd_chk(REG_RAMP_STYLE, 16'h0001);
		rd_chk(REG_ILIM, ILIM_DEFAULT_PCT);
		wr(REG_MOTOR_I, 16'h0032);
		rd_chk(REG_ILIM, 16'h014a);
		wr(REG_MOTOR_I, 16'h000a);
		rd_chk(REG_ILIM, ILIM_MAX_PCT);
		wr(REG_MOTOR_I, MOTOR_I_RST);
		rd_chk(4'hf, 16'h0000);
		wr(REG_DECEL_STEP, 16'h0001);
	endtask
	task t_ramp(input logic [1:0] rs);
		int c;
		wr(REG_RAMP_STYLE, {14'h0, rs});
		go(1'b0);
		chk(drv.volt_limit, (rs == 2'h2) ? 16'h01e0 : RATED_V_RST);
		term_set(1'b1, 1'b0, 1'b0);
		wait_sig(5, 1'b1, c);
		chk_in(c, 14, 26);
		wait_sig(0, 1'b0, c);
		chk_in(c, 28, 34);
	endtask
	task t_bus(input logic [1:0] rs);
		int c;
		wr(REG_RAMP_STYLE, {14'h0, rs});
		go(1'b0);
		bus_mode <= 2'h2;
		term_set(1'b1, 1'b0, 1'b0);
		repeat (30) @(posedge ref_clk);
		bus_mode <= 2'h1;
		repeat (10) @(posedge ref_clk);
		#1;
		chk(drv.freq, (rs == 2'h0) ? 16'h0000 : freq_ref);
		@(posedge ref_clk);
		bus_mode <= 2'h0;
		wait_sig(0, 1'b0, c);
		if (rs != 2'h0) chk_in(c, 40, 58);
	endtask
	task t_coast(input logic by_trip);
		int c;
		go(1'b0);
		@(posedge ref_clk);
		if (by_trip) trip <= 1'b1;
		else term.enable <= 1'b0;
		wait_sig(1, 1'b1, c);
		chk_in(c, 1, 8);
		@(posedge ref_clk);
		trip <= 1'b0;
		term_set(1'b1, 1'b1, 1'b0);
		wait_sig(1, 1'b0, c);
		chk_in(c, 34, 42);
		wait_sig(0, 1'b1, c);
		chk_in(c, 1, 8);
		term_set(1'b1, 1'b0, 1'b0);
		wait_sig(0, 1'b0, c);
	endtask
	task t_coast_style;
		int c;
		wr(REG_STOP_STYLE, 16'h0000);
		go(1'b0);
		term_set(1'b1, 1'b0, 1'b0);
		wait_sig(1, 1'b1, c);
		chk_in(c, 1, 8);
		wait_sig(1, 1'b0, c);
	endtask
	task t_dc;
		int c;
		wr(REG_STOP_STYLE, 16'h0002);
		wr(REG_INJ_LEVEL, 16'h0040);
		wr(REG_INJ_TIME, 16'h0002);
		go(1'b0);
		term_set(1'b1, 1'b0, 1'b0);
		wait_sig(2, 1'b1, c);
		chk_in(c, 14, 26);
		chk(drv.inj_level, 16'h0040);
		wait_sig(2, 1'b0, c);
		chk_in(c, 19, 21);
	endtask
	task t_zero_speed;
		int c;
		wr(REG_STOP_STYLE, 16'h0003);
		regen_stuck <= 1'b1;
		go(1'b0);
		term_set(1'b1, 1'b0, 1'b0);
		wait_sig(3, 1'b1, c);
		chk_in(c, 1, 8);
		term_set(1'b1, 1'b1, 1'b0);
		repeat (60) @(posedge ref_clk);
		#1;
		chk(16'(drv.inj_5hz), 16'h0001);
		regen_stuck <= 1'b0;
		wait_sig(2, 1'b1, c);
		chk_in(c, 1, 8);
		wait_sig(2, 1'b0, c);
		chk_in(c, 19, 21);
		wait_sig(0, 1'b1, c);
		chk_in(c, 1, 8);
		wr(REG_STOP_STYLE, 16'h0001);
		term_set(1'b1, 1'b0, 1'b0);
		wait_sig(0, 1'b0, c);
	endtask
	task t_timed;
		int c;
		wr(REG_STOP_STYLE, 16'h0004);
		for (int k = 0; k < 2; k++) begin
			wr(REG_INJ_TIME, 16'(3 * k));
			go(1'b0);
			term_set(1'b1, 1'b0, 1'b0);
			wait_sig(2, 1'b1, c);
			chk_in(c, 1, 8);
			wait_sig(2, 1'b0, c);
			chk_in(c, 39 + 20 * k, 41 + 20 * k);
		end
	endtask
	task t_reverse_and_keys;
		int c;
		wr(REG_STOP_STYLE, 16'h0001);
		go(1'b0);
		term_set(1'b1, 1'b0, 1'b1);
		wait_sig(4, 1'b1, c);
		chk_in(c, 20, 27);
		chk(16'(drv.bridge_en), 16'h0001);
		@(posedge ref_clk);
		freq_ref <= 16'h0020;
		term <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
		repeat (3) @(posedge ref_clk);
		#1;
		chk(drv.freq, 16'h0020);
		repeat (37) @(posedge ref_clk);
		freq_ref <= 16'h0010;
		term <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
		wait_sig(0, 1'b0, c);
		chk_in(c, 40, 60);
	endtask
	initial begin
		repeat (6) @(posedge ref_clk);
		arst_n <= 1'b1;
		t_regs();
		for (int r = 0; r < 3; r++) t_ramp(2'(r));
		t_bus(2'h1);
		t_bus(2'h0);
		t_coast(1'b0);
		t_coast(1'b1);
		t_coast_style();
		t_dc();
		t_zero_speed();
		t_timed();
		t_reverse_and_keys();
		close_out();
	end
	initial begin
		#100000;
		err_count++;
		close_out();
	end
endmodule
`default_nettype wire
